// [design/psaf_pkg.sv]
/*
 Package for the program space address former: register offsets, field
 positions, reset values, access kinds and the structs carried between the
 core side and program memory.
 Assumes a 16-bit data side, a 24-bit program word and one core clock.
*/
package psaf_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int PSAF_DW   = 16;
  localparam int PSAF_PW   = 24;
  localparam int PSAF_PGW  = 8;
  localparam int PSAF_RAW  = 4;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [PSAF_RAW-1:0] PSAF_OFS_TBLSEL = 4'h0;
  localparam logic [PSAF_RAW-1:0] PSAF_OFS_WINSEL = 4'h1;
  localparam logic [PSAF_RAW-1:0] PSAF_OFS_STATUS = 4'h2;
  localparam logic [PSAF_PGW-1:0] PSAF_RST_TBLSEL = 8'h00;
  localparam logic [PSAF_PGW-1:0] PSAF_RST_WINSEL = 8'h00;

  // Status fields
  localparam int PSAF_ST_WR_DROP  = 0;
  localparam int PSAF_ST_CFG_LAST = 1;

  // Field positions
  localparam int PSAF_CFG_BIT   = 7;
  localparam int PSAF_EA_MSB    = 15;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PSAF_LANE_LOW  = 2'h0,
    PSAF_LANE_HIGH = 2'h1,
    PSAF_LANE_UPPR = 2'h2
  } psaf_lane_t;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic                table_op;
    logic                byte_op;
    logic                upper;
    logic [PSAF_DW-1:0]  ea;
    logic [PSAF_DW-1:0]  wdata;
  } psaf_req_t;

  typedef struct packed {
    logic                rd;
    logic                wr;
    logic                cfg;
    logic [PSAF_PW-1:0]  addr;
    logic [2:0]          lane_en;
    logic [PSAF_PW-1:0]  wdata;
  } psaf_pm_t;

endpackage

// [design/psaf_top.sv]
/*
 Program space address former. Forms program-memory addresses for table
 operations and for the remapped read window, steers data-memory accesses,
 and returns read data to the core one cycle after the program memory answers.
 Assumes program memory answers one cycle after a read and that the core
 holds no request open across cycles.
*/
`timescale 1ns/10ps

module psaf_top
  import psaf_pkg::*;
(
  input  wire logic                 clk,         // Core clock 200 MHz
  input  wire logic                 reset_n,     // Async reset, low
  input  wire logic [PSAF_RAW-1:0]  reg_addr,    // Register address
  input  wire logic [PSAF_DW-1:0]   reg_wdata,   // Register write data
  input  wire logic                 reg_wr,      // Register write strobe
  input  wire logic                 reg_rd,      // Register read strobe
  output logic      [PSAF_DW-1:0]   reg_rdata,   // Register read data
  input  wire psaf_req_t            core_req,    // Core access request
  output logic      [PSAF_DW-1:0]   core_rdata,  // Read data to core
  output logic                      core_rvalid, // Read data valid
  output logic                      dm_sel,      // Data memory select
  output logic      [PSAF_DW-1:0]   dm_addr,     // Data memory address
  output psaf_pm_t                  pm_cmd,      // Program memory command
  input  wire logic [PSAF_PW-1:0]   pm_rdata     // Program memory word
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] lane_mask(input logic byte_op, input logic upper,
                                           input logic lsb);
    if (upper)
      lane_mask = 3'h4;
    else if (byte_op)
      lane_mask = lsb ? 3'h2 : 3'h1;
    else
      lane_mask = 3'h3;
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [PSAF_PGW-1:0] table_page_select_r;
  logic [PSAF_PGW-1:0] window_page_select_r;
  logic                wr_drop_r;
  logic                cfg_last_r;
  logic [PSAF_DW-1:0]  status_word;

  // Status bits at their field positions
  always_comb begin
    status_word                   = '0;
    status_word[PSAF_ST_WR_DROP]  = wr_drop_r;
    status_word[PSAF_ST_CFG_LAST] = cfg_last_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      table_page_select_r  <= PSAF_RST_TBLSEL;
      window_page_select_r <= PSAF_RST_WINSEL;
    end else if (reg_wr) begin
      if (reg_addr == PSAF_OFS_TBLSEL)
        table_page_select_r <= reg_wdata[PSAF_PGW-1:0];
      if (reg_addr == PSAF_OFS_WINSEL)
        window_page_select_r <= reg_wdata[PSAF_PGW-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        PSAF_OFS_TBLSEL: reg_rdata <= {8'h00, table_page_select_r};
        PSAF_OFS_WINSEL: reg_rdata <= {8'h00, window_page_select_r};
        PSAF_OFS_STATUS: reg_rdata <= status_word;
        default:         reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // Path decode
  // ------------------------------------------------------------
  logic is_table;
  logic is_window;
  logic is_data;
  logic [PSAF_PW-1:0] tbl_addr;
  logic [PSAF_PW-1:0] win_addr;

  assign is_table  = core_req.valid && core_req.table_op;
  assign is_window = core_req.valid && !core_req.table_op && core_req.ea[PSAF_EA_MSB];
  assign is_data   = core_req.valid && !core_req.table_op && !core_req.ea[PSAF_EA_MSB];

  assign tbl_addr = {table_page_select_r, core_req.ea};
  assign win_addr = {1'b0, window_page_select_r, core_req.ea[PSAF_EA_MSB-1:0]};

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_drop_r <= 1'b0;
    end else if (is_window && core_req.write) begin
      wr_drop_r <= 1'b1;
    end else if (reg_wr && reg_addr == PSAF_OFS_STATUS && reg_wdata[PSAF_ST_WR_DROP]) begin
      wr_drop_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cfg_last_r <= 1'b0;
    else if (is_table)
      cfg_last_r <= table_page_select_r[PSAF_CFG_BIT];
  end

  // ------------------------------------------------------------
  // Outputs to memories
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_cmd  <= '0;
      dm_sel  <= 1'b0;
      dm_addr <= '0;
    end else begin
      pm_cmd  <= '0;
      dm_sel  <= is_data;
      dm_addr <= is_data ? core_req.ea : '0;
      if (is_table) begin
        pm_cmd.rd      <= !core_req.write;
        pm_cmd.wr      <= core_req.write;
        pm_cmd.cfg     <= table_page_select_r[PSAF_CFG_BIT];
        pm_cmd.addr    <= tbl_addr;
        pm_cmd.lane_en <= lane_mask(core_req.byte_op, core_req.upper, core_req.ea[0]);
        pm_cmd.wdata   <= core_req.upper ? {core_req.wdata[7:0], 16'h0000}
                                         : {8'h00, core_req.wdata};
      end else if (is_window && !core_req.write) begin
        pm_cmd.rd      <= 1'b1;
        pm_cmd.cfg     <= 1'b0;
        pm_cmd.addr    <= win_addr;
        pm_cmd.lane_en <= 3'h3;
      end
    end
  end

  // ------------------------------------------------------------
  // Read return
  // ------------------------------------------------------------
  logic       pend_r;
  logic       pend_up_r;
  logic       pend_byte_r;
  logic       pend_odd_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r      <= 1'b0;
      pend_up_r   <= 1'b0;
      pend_byte_r <= 1'b0;
      pend_odd_r  <= 1'b0;
    end else begin
      pend_r      <= pm_cmd.rd;
      pend_up_r   <= pm_cmd.lane_en[2];
      pend_byte_r <= pm_cmd.lane_en != 3'h3;
      pend_odd_r  <= pm_cmd.lane_en == 3'h2;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_rvalid <= 1'b0;
      core_rdata  <= '0;
    end else begin
      core_rvalid <= pend_r;
      if (!pend_r)
        core_rdata <= '0;
      else if (pend_up_r)
        core_rdata <= {8'h00, pm_rdata[23:16]};
      else if (pend_byte_r)
        core_rdata <= {8'h00, pend_odd_r ? pm_rdata[15:8] : pm_rdata[7:0]};
      else
        core_rdata <= pm_rdata[15:0];
    end
  end

endmodule

// [verif/psaf_checker.sv]
/*
 Checker for the address former: ties memory commands to core requests.
 Assumes a bind onto psaf_top.
*/
`timescale 1ns/10ps
module psaf_checker
  import psaf_pkg::*;
(
  input wire logic                clk,         // Clock
  input wire logic                reset_n,     // Reset
  input wire logic [PSAF_RAW-1:0] reg_addr,    // Index
  input wire logic [PSAF_DW-1:0]  reg_wdata,   // Wdata
  input wire logic                reg_wr,      // Write
  input wire logic                reg_rd,      // Read
  input wire logic [PSAF_DW-1:0]  reg_rdata,   // Rdata
  input wire psaf_req_t           core_req,    // Request
  input wire logic [PSAF_DW-1:0]  core_rdata,  // Core data
  input wire logic                core_rvalid, // Valid
  input wire logic                dm_sel,      // Dm sel
  input wire logic [PSAF_DW-1:0]  dm_addr,     // Dm addr
  input wire psaf_pm_t            pm_cmd,      // Pm cmd
  input wire logic [PSAF_PW-1:0]  pm_rdata     // Pm word
);
  logic [7:0] tp_r;
  logic [7:0] wp_r;
  logic       tbl;
  logic       win;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the two page registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tp_r <= 8'h00;
      wp_r <= 8'h00;
    end else if (reg_wr && reg_addr == PSAF_OFS_TBLSEL) tp_r <= reg_wdata[7:0];
    else if (reg_wr && reg_addr == PSAF_OFS_WINSEL) wp_r <= reg_wdata[7:0];
  end
  assign tbl = core_req.valid && core_req.table_op;
  assign win = core_req.valid && !core_req.table_op && core_req.ea[15];
  a_tbl_addr: assert property (tbl |=> pm_cmd.addr == {$past(tp_r), $past(core_req.ea)})
    else $error("table address wrong");
  a_tbl_cfg: assert property (tbl |=> pm_cmd.cfg == $past(tp_r[7]))
    else $error("table target wrong");
  a_win_addr: assert property (win && !core_req.write |=> pm_cmd.rd &&
    pm_cmd.addr == {1'h0, $past(wp_r), $past(core_req.ea[14:0])}) else $error("window address wrong");
  a_win_user: assert property (win |=> !pm_cmd.cfg)
    else $error("window reached config");
  a_win_nowr: assert property (win && core_req.write |=> !pm_cmd.wr && !pm_cmd.rd)
    else $error("window write passed");
  a_rd_return: assert property (pm_cmd.rd && pm_cmd.lane_en == 3'h3 ##1 1'h1 |=>
    core_rvalid && core_rdata == $past(pm_rdata[15:0])) else $error("read return wrong");
  a_upper_lane: assert property (tbl && core_req.byte_op && core_req.upper |=> pm_cmd.lane_en == 3'h4)
    else $error("upper lane wrong");
  a_upper_return: assert property (pm_cmd.rd && pm_cmd.lane_en == 3'h4 ##1 1'h1 |=>
    core_rvalid && core_rdata == {8'h00, $past(pm_rdata[23:16])}) else $error("upper byte return wrong");
  a_data_route: assert property (core_req.valid && !core_req.table_op && !core_req.ea[15] |=>
    dm_sel && dm_addr == $past(core_req.ea) && !pm_cmd.rd) else $error("data route wrong");
  a_page_read: assert property (reg_rd && reg_addr == PSAF_OFS_TBLSEL |=> reg_rdata == {8'h00, $past(tp_r)})
    else $error("page readback wrong");
  c_win_rd: cover property (win && !core_req.write);
  c_win_wr: cover property (win && core_req.write);
  c_cfg: cover property (tbl && tp_r[7]);
endmodule

// [verif/psaf_pm_model.sv]
/*
 Program memory model: a read is answered with a word the next cycle.
 Assumes commands registered on the core clock.
*/
`timescale 1ns/10ps
module psaf_pm_model
  import psaf_pkg::*;
(
  input  wire logic          clk,      // Clock
  input  wire logic          reset_n,  // Reset
  input  wire psaf_pm_t      pm_cmd,   // Command
  output logic [PSAF_PW-1:0] pm_rdata  // Word
);
  // Word folds the address; toggles when not answering
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pm_rdata <= 24'h000000;
    else if (pm_cmd.rd) pm_rdata <= pm_cmd.addr ^ 24'h5AC3C3;
    else pm_rdata <= ~pm_rdata;
  end
endmodule

// [verif/psaf_tb_top.sv]
/*
 Bench for the address former: register and core access tasks.
 Assumes the package, psaf_top and the memory model compile first.
*/
`timescale 1ns/10ps
module psaf_tb_top import psaf_pkg::*;;
  logic        clk, reset_n, reg_wr, reg_rd, dm_sel, core_rvalid, rv, ds;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, core_rdata, dm_addr, rdt, da;
  logic [23:0] pm_rdata;
  psaf_req_t   core_req;
  psaf_pm_t    pm_cmd, pc;
  int          failures, checks;
  psaf_top uut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_req,
    .core_rdata, .core_rvalid, .dm_sel, .dm_addr, .pm_cmd, .pm_rdata);
  psaf_pm_model pmm (.clk, .reset_n, .pm_cmd, .pm_rdata);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task chk(input string n, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // Flags are table_op, write, byte_op, upper
  task req(input logic [3:0] f, input logic [15:0] ea, wd);
    @(posedge clk);
    core_req <= '{1'h1, f[2], f[3], f[1], f[0], ea, wd};
    @(posedge clk);
    core_req.valid <= 1'h0;
    #1 pc = pm_cmd;
    ds = dm_sel;
    da = dm_addr;
    repeat (2) @(posedge clk);
    #1 rv = core_rvalid;
    rdt = core_rdata;
  endtask
  task cmd(input logic [23:0] a, input logic [5:0] f);
    chk("pm_cmd.addr", a, pc.addr);
    chk("pm_cmd flags", {18'h0, f}, {18'h0, pc.rd, pc.wr, pc.cfg, pc.lane_en});
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #5000;
    failures++;
    give_verdict;
  end
  initial begin
    {failures, checks, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, core_req} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    rd(PSAF_OFS_TBLSEL, 16'h0000);
    rd(PSAF_OFS_WINSEL, 16'h0000);
    rd(4'hF, 16'h0000);
    $display("test registers done");
    wr(PSAF_OFS_TBLSEL, 16'hFF80);
    rd(PSAF_OFS_TBLSEL, 16'h0080);
    req(4'h8, 16'h1234, 16'h0000);
    cmd(24'h801234, 6'h2B);
    chk("core_rdata", {7'h0, 1'h1, 16'h1234 ^ 16'hC3C3}, {7'h0, rv, rdt});
    $display("test table read done");
    wr(PSAF_OFS_WINSEL, 16'h00FE);
    req(4'h0, 16'hFFFF, 16'h0000);
    cmd(24'h7F7FFF, 6'h23);
    chk("core_rdata", {7'h0, 1'h1, 16'h7FFF ^ 16'hC3C3}, {7'h0, rv, rdt});
    wr(PSAF_OFS_WINSEL, 16'h0003);
    req(4'h0, 16'h8005, 16'h0000);
    cmd(24'h018005, 6'h23);
    req(4'h4, 16'h8001, 16'h5555);
    chk("pm rd wr", 24'h0, {22'h0, pc.rd, pc.wr});
    rd(PSAF_OFS_STATUS, 16'h0003);
    wr(PSAF_OFS_STATUS, 16'h0001);
    rd(PSAF_OFS_STATUS, 16'h0002);
    $display("test window done");
    wr(PSAF_OFS_TBLSEL, 16'h0001);
    req(4'hC, 16'hABCD, 16'h1357);
    cmd(24'h01ABCD, 6'h13);
    chk("pm wdata", 24'h001357, {8'h00, pc.wdata[15:0]});
    req(4'hF, 16'hABCD, 16'h00EE);
    cmd(24'h01ABCD, 6'h14);
    chk("pm wdata", 24'h0000EE, {16'h0000, pc.wdata[23:16]});
    req(4'hE, 16'hABCD, 16'h0077);
    cmd(24'h01ABCD, 6'h12);
    req(4'h9, 16'hABCD, 16'h0000);
    cmd(24'h01ABCD, 6'h24);
    chk("core_rdata upper", {7'h0, 1'h1, 8'h00, 8'h01 ^ 8'h5A}, {7'h0, rv, rdt});
    req(4'hA, 16'hABCD, 16'h0000);
    cmd(24'h01ABCD, 6'h22);
    chk("core_rdata mid", {7'h0, 1'h1, 8'h00, 8'hAB ^ 8'hC3}, {7'h0, rv, rdt});
    req(4'hA, 16'hABCC, 16'h0000);
    cmd(24'h01ABCC, 6'h21);
    chk("core_rdata low", {7'h0, 1'h1, 8'h00, 8'hCC ^ 8'hC3}, {7'h0, rv, rdt});
    rd(PSAF_OFS_STATUS, 16'h0000);
    req(4'h0, 16'h7FFE, 16'h0000);
    chk("dm", {7'h0, 1'h1, 16'h7FFE}, {7'h0, ds, da});
    chk("pm rd", 24'h0, {23'h0, pc.rd});
    $display("test writes and data done");
    give_verdict;
  end
endmodule
bind psaf_top psaf_checker chk_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .core_req, .core_rdata, .core_rvalid, .dm_sel, .dm_addr, .pm_cmd, .pm_rdata);
